// >>> pkg/tcu_cfg.svh
`ifndef TCU_CFG_SVH
`define TCU_CFG_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define TCU_CNT_W        8
`define TCU_ADDR_W       8
`define TCU_PRE_W        10

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TCU_CTRL_OFS     8'h00
`define TCU_COUNT_OFS    8'h01
`define TCU_COMPARE_OFS  8'h02
`define TCU_FLAG_OFS     8'h03
`define TCU_MASK_OFS     8'h04

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TCU_CS_LSB       0
`define TCU_CS_MSB       2
`define TCU_WAVE_HI_BIT  3
`define TCU_WAVE_LO_BIT  6
`define TCU_OVF_BIT      0
`define TCU_CMP_BIT      1

// ---------------------------------------------------------------
// values
// ---------------------------------------------------------------
`define TCU_RESET_VAL    8'h00
`define TCU_BOTTOM       8'h00
`define TCU_MAX          8'hFF
`define TCU_STEP         8'h01
`define TCU_PRE_STEP     10'h001
`define TCU_PRE_MASK8    10'h007
`define TCU_PRE_MASK64   10'h03F
`define TCU_PRE_MASK256  10'h0FF
`define TCU_PRE_MASK1024 10'h3FF

`endif

// >>> pkg/tcu_pkg.sv
// ---------------------------------------------------------------
// types
// ---------------------------------------------------------------
package tcu_pkg;

  typedef enum logic [1:0] {
    TCU_WAVE_NORMAL,
    TCU_WAVE_PHASE_PWM,
    TCU_WAVE_CTC,
    TCU_WAVE_FAST_PWM
  } tcu_wave_t;

  typedef enum logic [2:0] {
    TCU_CS_STOP,
    TCU_CS_DIV1,
    TCU_CS_DIV8,
    TCU_CS_DIV64,
    TCU_CS_DIV256,
    TCU_CS_DIV1024,
    TCU_CS_EXT_FALL,
    TCU_CS_EXT_RISE
  } tcu_clksel_t;

endpackage : tcu_pkg

// >>> src/tcu_clock_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcu_cfg.svh"

module tcu_clock_select #(
  parameter int PRE_W = `TCU_PRE_W
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  clockSelect,
  input  wire logic        extClockPin,
  output logic             timerTick
);

  logic [PRE_W-1:0] preFf;
  logic [PRE_W-1:0] nxt_preFf;
  logic             extPrevFf;
  logic             nxt_extPrevFf;
  logic             tickFf;
  logic             nxt_tickFf;
  logic             extRise;
  logic             extFall;

  // ---------------------------------------------------------------
  // tick generation
  // ---------------------------------------------------------------
  // prescaler free-runs so switching taps never restarts its phase
  always_comb begin
    nxt_preFf     = preFf + PRE_W'(`TCU_PRE_STEP);
    nxt_extPrevFf = extClockPin;
    extRise       = extClockPin & ~extPrevFf;
    extFall       = ~extClockPin & extPrevFf;
    case (tcu_pkg::tcu_clksel_t'(clockSelect))
      tcu_pkg::TCU_CS_STOP:     nxt_tickFf = 1'b0;
      tcu_pkg::TCU_CS_DIV1:     nxt_tickFf = 1'b1;
      tcu_pkg::TCU_CS_DIV8:
        nxt_tickFf = (preFf & PRE_W'(`TCU_PRE_MASK8))
                     == PRE_W'(`TCU_PRE_MASK8);
      tcu_pkg::TCU_CS_DIV64:
        nxt_tickFf = (preFf & PRE_W'(`TCU_PRE_MASK64))
                     == PRE_W'(`TCU_PRE_MASK64);
      tcu_pkg::TCU_CS_DIV256:
        nxt_tickFf = (preFf & PRE_W'(`TCU_PRE_MASK256))
                     == PRE_W'(`TCU_PRE_MASK256);
      tcu_pkg::TCU_CS_DIV1024:
        nxt_tickFf = (preFf & PRE_W'(`TCU_PRE_MASK1024))
                     == PRE_W'(`TCU_PRE_MASK1024);
      tcu_pkg::TCU_CS_EXT_FALL: nxt_tickFf = extFall;
      tcu_pkg::TCU_CS_EXT_RISE: nxt_tickFf = extRise;
      default:                  nxt_tickFf = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preFf     <= '0;
      extPrevFf <= 1'b0;
      tickFf    <= 1'b0;
    end else begin
      preFf     <= nxt_preFf;
      extPrevFf <= nxt_extPrevFf;
      tickFf    <= nxt_tickFf;
    end
  end

  assign timerTick = tickFf;

endmodule : tcu_clock_select

`default_nettype wire

// >>> src/tcu_compare_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcu_cfg.svh"

module tcu_compare_unit #(
  parameter int CNT_W = `TCU_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             wrEn,
  input  wire logic [CNT_W-1:0] wrData,
  input  wire logic             pwmMode,
  input  wire logic             loadPoint,
  input  wire logic [CNT_W-1:0] counterValue,
  output logic      [CNT_W-1:0] bufferValue,
  output logic      [CNT_W-1:0] activeValue,
  output logic                  match
);

  logic [CNT_W-1:0] bufFf;
  logic [CNT_W-1:0] nxt_bufFf;
  logic [CNT_W-1:0] actFf;
  logic [CNT_W-1:0] nxt_actFf;

  // ---------------------------------------------------------------
  // double buffer
  // ---------------------------------------------------------------
  // pwm modes only load at top to avoid odd-length pulses
  always_comb begin
    nxt_bufFf = wrEn ? wrData : bufFf;
    if (!pwmMode || loadPoint) begin
      nxt_actFf = nxt_bufFf;
    end else begin
      nxt_actFf = actFf;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bufFf <= '0;
      actFf <= '0;
    end else begin
      bufFf <= nxt_bufFf;
      actFf <= nxt_actFf;
    end
  end

  assign bufferValue = bufFf;
  assign activeValue = actFf;
  assign match       = (counterValue == actFf);

endmodule : tcu_compare_unit

`default_nettype wire

// >>> src/tcu_timer_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcu_cfg.svh"

module tcu_timer_counter #(
  parameter int ADDR_W = `TCU_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  input  wire logic              extClockPin,
  input  wire logic              overflowAck,
  input  wire logic              compareAck,
  output logic      [7:0]        rdData,
  output logic                   overflowIrq,
  output logic                   compareIrq,
  output logic                   compareMatch,
  output logic                   topInd,
  output logic                   bottomInd
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0]              clockSelectFf;
  logic [2:0]              nxt_clockSelectFf;
  tcu_pkg::tcu_wave_t      waveModeFf;
  tcu_pkg::tcu_wave_t      nxt_waveModeFf;
  logic [7:0]              countFf;
  logic [7:0]              nxt_countFf;
  logic                    countUpFf;
  logic                    nxt_countUpFf;
  logic                    blockFf;
  logic                    nxt_blockFf;
  logic                    overflowFlagFf;
  logic                    nxt_overflowFlagFf;
  logic                    compareFlagFf;
  logic                    nxt_compareFlagFf;
  logic                    overflowMaskFf;
  logic                    nxt_overflowMaskFf;
  logic                    compareMaskFf;
  logic                    nxt_compareMaskFf;
  logic [7:0]              rdDataFf;
  logic [7:0]              nxt_rdDataFf;
  logic                    overflowIrqFf;
  logic                    nxt_overflowIrqFf;
  logic                    compareIrqFf;
  logic                    nxt_compareIrqFf;
  logic                    matchFf;
  logic                    nxt_matchFf;
  logic                    topFf;
  logic                    nxt_topFf;
  logic                    bottomFf;
  logic                    nxt_bottomFf;

  logic                    timerTick;
  logic                    rawMatch;
  logic [7:0]              compareBuf;
  logic                    wrCtrl;
  logic                    wrCount;
  logic                    wrCompare;
  logic                    wrFlag;
  logic                    wrMask;
  logic                    pwmMode;
  logic                    atMax;
  logic                    atBottom;
  logic                    loadPoint;
  logic                    overflowSet;
  logic                    compareSet;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  function automatic logic [7:0] step(input logic [7:0] v,
                                      input logic       up);
    step = up ? 8'(v + `TCU_STEP) : 8'(v - `TCU_STEP);
  endfunction : step

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  tcu_clock_select #(
    .PRE_W       (`TCU_PRE_W)
  ) u_clock_select (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .clockSelect (clockSelectFf),
    .extClockPin (extClockPin),
    .timerTick   (timerTick)
  );

  tcu_compare_unit #(
    .CNT_W        (`TCU_CNT_W)
  ) u_compare_unit (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .wrEn         (wrCompare),
    .wrData       (wrData),
    .pwmMode      (pwmMode),
    .loadPoint    (loadPoint),
    .counterValue (countFf),
    .bufferValue  (compareBuf),
    .activeValue  (),
    .match        (rawMatch)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign wrCtrl    = wrStb & hit(addr, `TCU_CTRL_OFS);
  assign wrCount   = wrStb & hit(addr, `TCU_COUNT_OFS);
  assign wrCompare = wrStb & hit(addr, `TCU_COMPARE_OFS);
  assign wrFlag    = wrStb & hit(addr, `TCU_FLAG_OFS);
  assign wrMask    = wrStb & hit(addr, `TCU_MASK_OFS);
  assign pwmMode   = (waveModeFf == tcu_pkg::TCU_WAVE_PHASE_PWM) |
                     (waveModeFf == tcu_pkg::TCU_WAVE_FAST_PWM);
  assign atMax     = (countFf == `TCU_MAX);
  assign atBottom  = (countFf == `TCU_BOTTOM);
  assign loadPoint = timerTick & atMax;

  // ---------------------------------------------------------------
  // control and mask registers
  // ---------------------------------------------------------------
  always_comb begin
    nxt_clockSelectFf  = clockSelectFf;
    nxt_waveModeFf     = waveModeFf;
    nxt_overflowMaskFf = overflowMaskFf;
    nxt_compareMaskFf  = compareMaskFf;
    if (wrCtrl) begin
      nxt_clockSelectFf = wrData[`TCU_CS_MSB:`TCU_CS_LSB];
      nxt_waveModeFf    = tcu_pkg::tcu_wave_t'(
        {wrData[`TCU_WAVE_HI_BIT], wrData[`TCU_WAVE_LO_BIT]});
    end
    if (wrMask) begin
      nxt_overflowMaskFf = wrData[`TCU_OVF_BIT];
      nxt_compareMaskFf  = wrData[`TCU_CMP_BIT];
    end
  end

  // ---------------------------------------------------------------
  // counter unit
  // ---------------------------------------------------------------
  always_comb begin
    nxt_countFf   = countFf;
    nxt_countUpFf = countUpFf;
    overflowSet   = 1'b0;
    if (timerTick) begin
      case (waveModeFf)
        tcu_pkg::TCU_WAVE_NORMAL: begin
          nxt_countUpFf = 1'b1;
          nxt_countFf   = step(countFf, 1'b1);
          overflowSet   = atMax;
        end
        tcu_pkg::TCU_WAVE_CTC: begin
          nxt_countUpFf = 1'b1;
          if (rawMatch) begin
            nxt_countFf = `TCU_BOTTOM;
          end else begin
            nxt_countFf = step(countFf, 1'b1);
          end
          overflowSet   = atMax;
        end
        tcu_pkg::TCU_WAVE_FAST_PWM: begin
          nxt_countUpFf = 1'b1;
          nxt_countFf   = step(countFf, 1'b1);
          overflowSet   = atMax;
        end
        tcu_pkg::TCU_WAVE_PHASE_PWM: begin
          // turn round at both ends so max and bottom last one tick
          if (atMax) begin
            nxt_countUpFf = 1'b0;
          end else if (atBottom) begin
            nxt_countUpFf = 1'b1;
          end
          nxt_countFf = step(countFf, nxt_countUpFf);
          overflowSet = atBottom;
        end
        default: begin
          nxt_countFf = countFf;
        end
      endcase
    end
    if (wrCount) begin
      nxt_countFf = wrData;
    end
  end

  // ---------------------------------------------------------------
  // match blocking and flags
  // ---------------------------------------------------------------
  // a counter write arms the block even when stopped; a tick spends it
  always_comb begin
    if (wrCount) begin
      nxt_blockFf = 1'b1;
    end else if (timerTick) begin
      nxt_blockFf = 1'b0;
    end else begin
      nxt_blockFf = blockFf;
    end
    compareSet  = timerTick & rawMatch & ~blockFf;
    nxt_matchFf = compareSet;
    nxt_overflowFlagFf = overflowFlagFf;
    nxt_compareFlagFf  = compareFlagFf;
    if (overflowAck | (wrFlag & wrData[`TCU_OVF_BIT])) begin
      nxt_overflowFlagFf = 1'b0;
    end
    if (compareAck | (wrFlag & wrData[`TCU_CMP_BIT])) begin
      nxt_compareFlagFf = 1'b0;
    end
    // set beats clear so no event is lost
    if (overflowSet) begin
      nxt_overflowFlagFf = 1'b1;
    end
    if (compareSet) begin
      nxt_compareFlagFf = 1'b1;
    end
    nxt_overflowIrqFf = nxt_overflowFlagFf & nxt_overflowMaskFf;
    nxt_compareIrqFf  = nxt_compareFlagFf & nxt_compareMaskFf;
    nxt_topFf         = (nxt_countFf == `TCU_MAX);
    nxt_bottomFf      = (nxt_countFf == `TCU_BOTTOM);
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdDataFf = 8'h00;
    if (rdStb) begin
      if (hit(addr, `TCU_CTRL_OFS)) begin
        nxt_rdDataFf[`TCU_CS_MSB:`TCU_CS_LSB] = clockSelectFf;
        nxt_rdDataFf[`TCU_WAVE_HI_BIT]        = waveModeFf[1];
        nxt_rdDataFf[`TCU_WAVE_LO_BIT]        = waveModeFf[0];
      end else if (hit(addr, `TCU_COUNT_OFS)) begin
        nxt_rdDataFf = countFf;
      end else if (hit(addr, `TCU_COMPARE_OFS)) begin
        nxt_rdDataFf = compareBuf;
      end else if (hit(addr, `TCU_FLAG_OFS)) begin
        nxt_rdDataFf[`TCU_OVF_BIT] = overflowFlagFf;
        nxt_rdDataFf[`TCU_CMP_BIT] = compareFlagFf;
      end else if (hit(addr, `TCU_MASK_OFS)) begin
        nxt_rdDataFf[`TCU_OVF_BIT] = overflowMaskFf;
        nxt_rdDataFf[`TCU_CMP_BIT] = compareMaskFf;
      end else begin
        nxt_rdDataFf = 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clockSelectFf  <= 3'h0;
      waveModeFf     <= tcu_pkg::TCU_WAVE_NORMAL;
      countFf        <= `TCU_RESET_VAL;
      countUpFf      <= 1'b1;
      blockFf        <= 1'b0;
      overflowFlagFf <= 1'b0;
      compareFlagFf  <= 1'b0;
      overflowMaskFf <= 1'b0;
      compareMaskFf  <= 1'b0;
      rdDataFf       <= 8'h00;
      overflowIrqFf  <= 1'b0;
      compareIrqFf   <= 1'b0;
      matchFf        <= 1'b0;
      topFf          <= 1'b0;
      bottomFf       <= 1'b1;
    end else begin
      clockSelectFf  <= nxt_clockSelectFf;
      waveModeFf     <= nxt_waveModeFf;
      countFf        <= nxt_countFf;
      countUpFf      <= nxt_countUpFf;
      blockFf        <= nxt_blockFf;
      overflowFlagFf <= nxt_overflowFlagFf;
      compareFlagFf  <= nxt_compareFlagFf;
      overflowMaskFf <= nxt_overflowMaskFf;
      compareMaskFf  <= nxt_compareMaskFf;
      rdDataFf       <= nxt_rdDataFf;
      overflowIrqFf  <= nxt_overflowIrqFf;
      compareIrqFf   <= nxt_compareIrqFf;
      matchFf        <= nxt_matchFf;
      topFf          <= nxt_topFf;
      bottomFf       <= nxt_bottomFf;
    end
  end

  assign rdData       = rdDataFf;
  assign overflowIrq  = overflowIrqFf;
  assign compareIrq   = compareIrqFf;
  assign compareMatch = matchFf;
  assign topInd       = topFf;
  assign bottomInd    = bottomFf;

endmodule : tcu_timer_counter

`default_nettype wire

// >>> dv/tcu_timer_counter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcu_cfg.svh"

module tcu_timer_counter_asserts #(
  parameter int ADDR_W = `TCU_ADDR_W
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0]        wrData,
  input wire logic              wrStb,
  input wire logic              rdStb,
  input wire logic [7:0]        rdData,
  input wire logic              overflowIrq,
  input wire logic              compareIrq,
  input wire logic              compareMatch,
  input wire logic              topInd,
  input wire logic              bottomInd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_rd_idle_zero: assert property (!rdStb |=> rdData == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (
    rdStb && addr > `TCU_MASK_OFS |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_spare: assert property (rdStb && addr == `TCU_CTRL_OFS
    |=> rdData[7] == 1'h0 && rdData[5:4] == 2'h0)
    else $error("spare control bits not zero");
  a_flag_spare: assert property (rdStb && addr == `TCU_FLAG_OFS
    |=> rdData[7:2] == 6'h00)
    else $error("spare flag bits not zero");
  a_cmp_readback: assert property (
    wrStb && addr == `TCU_COMPARE_OFS ##1 !wrStb
    ##1 rdStb && addr == `TCU_COMPARE_OFS
    |=> rdData == $past(wrData, 3))
    else $error("compare value not read back");
  a_ind_exclusive: assert property (!(topInd && bottomInd))
    else $error("top and bottom together");
  a_reset_state: assert property ($fell(sys_rst) |-> bottomInd
    && !topInd && !compareIrq && !overflowIrq && !compareMatch)
    else $error("outputs wrong after reset");
  a_cmp_irq_cause: assert property ($rose(compareIrq) |->
    compareMatch || $past(compareMatch) || $past(wrStb) || $past(wrStb, 2))
    else $error("compare irq without match");
  a_ovf_irq_cause: assert property ($rose(overflowIrq) |->
    bottomInd || $past(bottomInd) || $past(bottomInd, 2)
    || $past(wrStb) || $past(wrStb, 2))
    else $error("overflow irq without wrap");

  c_match: cover property (compareMatch);
  c_ovf_irq: cover property ($rose(overflowIrq));
  c_top: cover property ($rose(topInd));
endmodule : tcu_timer_counter_asserts

bind tcu_timer_counter tcu_timer_counter_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wrData(wrData),
  .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .overflowIrq(overflowIrq), .compareIrq(compareIrq),
  .compareMatch(compareMatch), .topInd(topInd), .bottomInd(bottomInd));

`default_nettype wire

// >>> dv/tb_tcu_timer_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcu_cfg.svh"

module tb_tcu_timer_counter;
  localparam logic [7:0] CTL = `TCU_CTRL_OFS;
  localparam logic [7:0] CNT = `TCU_COUNT_OFS;
  localparam logic [7:0] CMP = `TCU_COMPARE_OFS;
  localparam logic [7:0] FLG = `TCU_FLAG_OFS;
  localparam logic [7:0] MSK = `TCU_MASK_OFS;
  logic       clk         = 1'h0;
  logic       sys_rst     = 1'h1;
  logic [7:0] addr        = 8'h00;
  logic [7:0] wrData      = 8'h00;
  logic       wrStb       = 1'h0;
  logic       rdStb       = 1'h0;
  logic       extClockPin = 1'h0;
  logic       overflowAck = 1'h0;
  logic       compareAck  = 1'h0;
  logic [7:0] rdData;
  logic       overflowIrq;
  logic       compareIrq;
  logic       compareMatch;
  logic       topInd;
  logic       bottomInd;
  int         n_errors    = 0;
  int         tests_run   = 0;
  int         nMatch      = 0;

  always #5 clk = ~clk;
  // counted on the falling edge so the registered pulse has settled
  always @(negedge clk) if (compareMatch === 1'h1) nMatch++;

  tcu_timer_counter dut (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .extClockPin(extClockPin),
    .overflowAck(overflowAck), .compareAck(compareAck), .rdData(rdData),
    .overflowIrq(overflowIrq), .compareIrq(compareIrq),
    .compareMatch(compareMatch), .topInd(topInd), .bottomInd(bottomInd));

  // ---------------------------------------------------------------
  // bus and pin helpers
  // ---------------------------------------------------------------
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'h1;
    @(posedge clk);
    wrStb  <= 1'h0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] e, input string w);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'h1;
    @(posedge clk);
    rdStb <= 1'h0;
    #1;
    chk(w, e, rdData & m);
  endtask : rdchk

  // pin held for three cycles each way: the edge needs two to land
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) extClockPin <= 1'h1;
      repeat (3) @(posedge clk);
      extClockPin <= 1'h0;
      repeat (3) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse

  task automatic give_ack(input logic cmp);
    @(posedge clk);
    overflowAck <= ~cmp;
    compareAck  <= cmp;
    @(posedge clk);
    overflowAck <= 1'h0;
    compareAck  <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask : give_ack

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset;
    for (int a = 0; a < 6; a++)
      rdchk(8'(a), 8'hFF, 8'h00, "reset register");
    chk("bottom at reset", 8'h01, {7'h0, bottomInd});
    chk("top at reset", 8'h00, {7'h0, topInd});
    $display("test_reset done");
  endtask : test_reset

  task automatic test_regs;
    wr(CMP, 8'hA5);
    rdchk(CMP, 8'hFF, 8'hA5, "compare");
    wr(CNT, 8'h5A);
    rdchk(CNT, 8'hFF, 8'h5A, "counter");
    wr(CTL, 8'hB0);
    rdchk(CTL, 8'hFF, 8'h00, "control spare");
    wr(CTL, 8'h4F);
    rdchk(CTL, 8'hFF, 8'h4F, "control");
    wr(CTL, 8'h00);
    wr(MSK, 8'h03);
    rdchk(MSK, 8'h03, 8'h03, "mask");
    wr(8'hFF, 8'hFF);
    rdchk(8'hFF, 8'hFF, 8'h00, "unmapped");
    repeat (20) @(posedge clk);
    rdchk(CNT, 8'hFF, 8'h5A, "stopped counter");
    $display("test_regs done");
  endtask : test_regs

  task automatic test_edges;
    wr(CNT, 8'hFE);
    wr(CTL, 8'h07);
    pulse(1);
    chk("top", 8'h01, {7'h0, topInd});
    pulse(1);
    chk("bottom", 8'h01, {7'h0, bottomInd});
    wr(CTL, 8'h06);
    @(posedge clk) extClockPin <= 1'h1;
    repeat (6) @(posedge clk);
    rdchk(CNT, 8'hFF, 8'h00, "rise ignored");
    @(posedge clk) extClockPin <= 1'h0;
    repeat (6) @(posedge clk);
    rdchk(CNT, 8'hFF, 8'h01, "fall counted");
    $display("test_edges done");
  endtask : test_edges

  task automatic test_modes;
    logic [7:0] cnt[4] = '{8'h00, 8'hFD, 8'h00, 8'h00};
    int         np[4]  = '{2, 3, 2, 2};
    logic [7:0] ovf[4] = '{8'h01, 8'h00, 8'h01, 8'h01};
    wr(CMP, 8'h10);
    wr(MSK, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(CTL, 8'h00);
      wr(FLG, 8'h03);
      wr(CNT, 8'hFE);
      wr(CTL, {1'h0, m[0], 2'h0, m[1], 3'h7});
      pulse(np[m]);
      wr(CTL, 8'h00);
      rdchk(CNT, 8'hFF, cnt[m], "mode count");
      rdchk(FLG, 8'h01, ovf[m], "overflow flag");
      chk("overflow irq", ovf[m], {7'h0, overflowIrq});
    end
    wr(MSK, 8'h00);
    rdchk(FLG, 8'h01, 8'h01, "masked flag");
    chk("masked irq", 8'h00, {7'h0, overflowIrq});
    give_ack(1'h0);
    rdchk(FLG, 8'h01, 8'h00, "overflow ack");
    $display("test_modes done");
  endtask : test_modes

  task automatic test_ctc;
    wr(FLG, 8'h03);
    wr(MSK, 8'h02);
    wr(CMP, 8'h03);
    wr(CNT, 8'h00);
    nMatch = 0;
    wr(CTL, 8'h0F);
    pulse(3);
    chk("early match", 8'h00, 8'(nMatch));
    pulse(1);
    chk("match", 8'h01, 8'(nMatch));
    rdchk(CNT, 8'hFF, 8'h00, "clear on match");
    rdchk(FLG, 8'h02, 8'h02, "compare flag");
    chk("compare irq", 8'h01, {7'h0, compareIrq});
    wr(FLG, 8'h02);
    rdchk(FLG, 8'h02, 8'h00, "flag write one");
    chk("irq cleared", 8'h00, {7'h0, compareIrq});
    pulse(4);
    chk("irq again", 8'h01, {7'h0, compareIrq});
    give_ack(1'h1);
    chk("irq after ack", 8'h00, {7'h0, compareIrq});
    wr(CTL, 8'h07);
    wr(CNT, 8'h03);
    pulse(1);
    chk("blocked match", 8'h02, 8'(nMatch));
    rdchk(CNT, 8'hFF, 8'h04, "one step");
    @(posedge clk) extClockPin <= 1'h1;
    // strobe is sampled on the same edge as the tick it must override
    wr(CNT, 8'h40);
    repeat (4) @(posedge clk);
    extClockPin <= 1'h0;
    rdchk(CNT, 8'hFF, 8'h40, "write beats tick");
    $display("test_ctc done");
  endtask : test_ctc

  task automatic test_prescale;
    int div[5] = '{1, 8, 64, 256, 1024};
    for (int k = 0; k < 5; k++) begin
      wr(CTL, 8'h00);
      wr(CNT, 8'h00);
      wr(CTL, 8'(k + 1));
      repeat (8 * div[k] - 2) @(posedge clk);
      wr(CTL, 8'h00);
      // free-running prescaler phase: the masked check takes any count from 0 to 15
      rdchk(CNT, 8'hF0, 8'h00, "prescaled count");
      rdchk(CNT, 8'hFF, 8'h08, "prescaled exact");
    end
    $display("test_prescale done");
  endtask : test_prescale

  // ---------------------------------------------------------------
  // sequence and verdict
  // ---------------------------------------------------------------
  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    give_verdict;
  end

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    test_reset;
    test_regs;
    test_edges;
    test_modes;
    test_ctc;
    test_prescale;
    give_verdict;
  end
endmodule : tb_tcu_timer_counter

`default_nettype wire
